//--- common/uart_ier_pkg.sv
package uart_ier_pkg;
	localparam int ADDR_W = 5;
	localparam logic [ADDR_W-1:0] OFS_DIV_LOW = 5'h00;
	localparam logic [ADDR_W-1:0] OFS_IRQ_EN_DIV_HIGH = 5'h04;
	localparam logic [ADDR_W-1:0] OFS_IDENT = 5'h08;
	localparam logic [ADDR_W-1:0] OFS_LINE_CTRL = 5'h0C;
	localparam logic [ADDR_W-1:0] OFS_AUX_CTRL = 5'h10;
	localparam logic [ADDR_W-1:0] OFS_EVT_STATUS = 5'h14;
	localparam logic [ADDR_W-1:0] OFS_EVT_MASK = 5'h18;

	localparam int DIV_SEL_BIT = 7;
	localparam int FIFO_EN_BIT = 0;
	localparam int AUX_THRESH_BIT = 0;
	localparam int IE_RX_AVAIL = 0;
	localparam int IE_TX_EMPTY = 1;
	localparam int IE_RX_ERROR = 2;
	localparam int IE_LINE_CHG = 3;
	localparam int IDENT_ID_HI = 3;
	localparam int IDENT_FIFO_LO = 6;
	localparam int IDENT_FIFO_HI = 7;

	localparam logic [3:0] ID_RX_ERROR = 4'h6;
	localparam logic [3:0] ID_RX_AVAIL = 4'h4;
	localparam logic [3:0] ID_CHAR_TMO = 4'hC;
	localparam logic [3:0] ID_TX_EMPTY = 4'h2;
	localparam logic [3:0] ID_MODEM = 4'h0;
	localparam logic [3:0] ID_NONE = 4'h1;

	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [3:0] RST_IRQ_EN = 4'h0;
	localparam logic [3:0] RST_IDENT_ID = ID_NONE;

	localparam int EV_RX_ERROR = 0;
	localparam int EV_RX_AVAIL = 1;
	localparam int EV_CHAR_TMO = 2;
	localparam int EV_TX_EMPTY = 3;
	localparam int EV_MODEM = 4;
	localparam int EV_W = 5;
	typedef logic [EV_W-1:0] event_vec_t;
	localparam event_vec_t RST_EVENTS = 5'h00;

	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	localparam int BAUD_OVERSAMPLE = 16;
	localparam logic [3:0] OS_LAST = 4'(BAUD_OVERSAMPLE - 1);
	localparam logic [15:0] DIV_OFF = 16'h0000;
	localparam logic [15:0] DIV_ONE = 16'h0001;
endpackage

//--- common/baud_if.sv
`timescale 1ns/100ps
interface baud_if;
	logic [15:0] divisor;
	logic tick_x16;
	logic tick;
	modport gen (input divisor, output tick_x16, output tick);
	modport ctl (output divisor, input tick_x16, input tick);
endinterface

//--- hdl/baud_gen.sv
`timescale 1ns/100ps
module baud_gen
(
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_b_in,
	// Divisor in, ticks out
	baud_if.gen baud
);
	import uart_ier_pkg::*;

	logic [15:0] div_cnt;
	logic [3:0] os_cnt;
	wire div_off = (baud.divisor == DIV_OFF);
	wire div_wrap = (div_cnt >= baud.divisor - DIV_ONE);

	always_ff @(posedge clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			div_cnt <= DIV_OFF;
			os_cnt <= 4'h0;
			baud.tick_x16 <= 1'b0;
			baud.tick <= 1'b0;
		end
		else if (div_off)
		begin
			div_cnt <= DIV_OFF;
			os_cnt <= 4'h0;
			baud.tick_x16 <= 1'b0;
			baud.tick <= 1'b0;
		end
		else
		begin
			div_cnt <= div_wrap ? DIV_OFF : div_cnt + DIV_ONE;
			baud.tick_x16 <= div_wrap;
			baud.tick <= div_wrap && (os_cnt == OS_LAST);
			if (div_wrap)
				os_cnt <= (os_cnt == OS_LAST) ? 4'h0 : os_cnt + 4'h1;
		end
	end

	AST_BAUD_ZERO:
	assert property (@(posedge clk_in) disable iff (!rst_b_in)
		div_off |=> !baud.tick_x16 && !baud.tick)
	else $error("baud tick with zero divisor");

	AST_BAUD_FAST:
	assert property (@(posedge clk_in) disable iff (!rst_b_in)
		(baud.divisor == DIV_ONE)[*2] |-> baud.tick_x16)
	else $error("divisor one must tick every cycle");

	AST_BAUD_NESTED:
	assert property (@(posedge clk_in) disable iff (!rst_b_in)
		baud.tick |-> baud.tick_x16 && $past(os_cnt) == OS_LAST)
	else $error("baud tick not on sixteenth sub tick");
endmodule

//--- hdl/uart_irq_ident.sv
`timescale 1ns/100ps
module uart_irq_ident
(
	// Clock and reset
	input wire logic sys_clk_in,
	input wire logic rst_b_in,
	// AXI4-Lite write address and data
	input wire logic s_axi_awvalid_in,
	output logic s_axi_awready_out,
	input wire logic [uart_ier_pkg::ADDR_W-1:0] s_axi_awaddr_in,
	input wire logic s_axi_wvalid_in,
	output logic s_axi_wready_out,
	input wire logic [31:0] s_axi_wdata_in,
	input wire logic [3:0] s_axi_wstrb_in,
	// AXI4-Lite write response
	output logic s_axi_bvalid_out,
	input wire logic s_axi_bready_in,
	output logic [1:0] s_axi_bresp_out,
	// AXI4-Lite read
	input wire logic s_axi_arvalid_in,
	output logic s_axi_arready_out,
	input wire logic [uart_ier_pkg::ADDR_W-1:0] s_axi_araddr_in,
	output logic s_axi_rvalid_out,
	input wire logic s_axi_rready_in,
	output logic [31:0] s_axi_rdata_out,
	output logic [1:0] s_axi_rresp_out,
	// Interrupt sources, same clock
	input wire logic rx_error_in,
	input wire logic rx_avail_in,
	input wire logic char_timeout_in,
	input wire logic tx_empty_in,
	input wire logic tx_low_in,
	input wire logic modem_change_in,
	// Status outputs
	output logic irq_out,
	output logic fifo_enable_out,
	output logic baud_tick_out,
	output logic baud_x16_tick_out
);
	import uart_ier_pkg::*;

	function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
		return (a == OFS_DIV_LOW) || (a == OFS_IRQ_EN_DIV_HIGH) || (a == OFS_IDENT) ||
			(a == OFS_LINE_CTRL) || (a == OFS_AUX_CTRL) || (a == OFS_EVT_STATUS) ||
			(a == OFS_EVT_MASK);
	endfunction

	function automatic logic [3:0] prio_code(input event_vec_t p);
		if (p[EV_RX_ERROR])
			return ID_RX_ERROR;
		else if (p[EV_RX_AVAIL])
			return ID_RX_AVAIL;
		else if (p[EV_CHAR_TMO])
			return ID_CHAR_TMO;
		else if (p[EV_TX_EMPTY])
			return ID_TX_EMPTY;
		else if (p[EV_MODEM])
			return ID_MODEM;
		else
			return ID_NONE;
	endfunction

	// Reset release
	logic rst_meta;
	logic rst_sync;

	always_ff @(posedge sys_clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			rst_meta <= 1'b0;
			rst_sync <= 1'b0;
		end
		else
		begin
			rst_meta <= 1'b1;
			rst_sync <= rst_meta;
		end
	end

	// Register state
	logic [7:0] div_low;
	logic [7:0] div_high;
	logic [3:0] irq_en;
	logic [7:0] line_ctrl;
	logic aux_thresh;
	logic fifo_en;
	logic [3:0] ident_id;
	event_vec_t evt_status;
	event_vec_t evt_mask;
	event_vec_t pend_q;

	// Write channel capture
	logic aw_full;
	logic w_full;
	logic [ADDR_W-1:0] aw_addr_q;
	logic [31:0] w_data_q;
	logic w_lane0_q;

	wire aw_hs = s_axi_awvalid_in && s_axi_awready_out;
	wire w_hs = s_axi_wvalid_in && s_axi_wready_out;
	wire wr_fire = aw_full && w_full && !s_axi_bvalid_out;
	wire next_aw_full = aw_hs || (aw_full && !wr_fire);
	wire next_w_full = w_hs || (w_full && !wr_fire);
	wire next_bvalid = wr_fire || (s_axi_bvalid_out && !s_axi_bready_in);

	always_ff @(posedge sys_clk_in or negedge rst_sync)
	begin
		if (!rst_sync)
		begin
			aw_full <= 1'b0;
			w_full <= 1'b0;
			aw_addr_q <= OFS_DIV_LOW;
			w_data_q <= 32'h0000_0000;
			w_lane0_q <= 1'b0;
			s_axi_awready_out <= 1'b0;
			s_axi_wready_out <= 1'b0;
			s_axi_bvalid_out <= 1'b0;
			s_axi_bresp_out <= RESP_OKAY;
		end
		else
		begin
			aw_full <= next_aw_full;
			w_full <= next_w_full;
			s_axi_awready_out <= !next_aw_full;
			s_axi_wready_out <= !next_w_full;
			s_axi_bvalid_out <= next_bvalid;
			if (aw_hs)
				aw_addr_q <= s_axi_awaddr_in;
			if (w_hs)
			begin
				w_data_q <= s_axi_wdata_in;
				w_lane0_q <= s_axi_wstrb_in[0];
			end
			if (wr_fire)
				s_axi_bresp_out <= is_mapped(aw_addr_q) ? RESP_OKAY : RESP_SLVERR;
		end
	end

	// Write decode
	wire div_sel = line_ctrl[DIV_SEL_BIT];
	wire wr_lane0 = wr_fire && w_lane0_q;
	wire [7:0] wr_byte = w_data_q[7:0];
	wire wr_div_low = wr_lane0 && (aw_addr_q == OFS_DIV_LOW) && div_sel;
	wire wr_div_high = wr_lane0 && (aw_addr_q == OFS_IRQ_EN_DIV_HIGH) && div_sel;
	wire wr_irq_en = wr_lane0 && (aw_addr_q == OFS_IRQ_EN_DIV_HIGH) && !div_sel;
	wire wr_fifo_ctrl = wr_lane0 && (aw_addr_q == OFS_IDENT);
	wire wr_line = wr_lane0 && (aw_addr_q == OFS_LINE_CTRL);
	wire wr_aux = wr_lane0 && (aw_addr_q == OFS_AUX_CTRL);
	wire wr_status = wr_lane0 && (aw_addr_q == OFS_EVT_STATUS);
	wire wr_mask = wr_lane0 && (aw_addr_q == OFS_EVT_MASK);

	// Divisor latch, both bytes
	always_ff @(posedge sys_clk_in or negedge rst_sync)
	begin
		if (!rst_sync)
		begin
			div_low <= RST_BYTE;
			div_high <= RST_BYTE;
		end
		else
		begin
			if (wr_div_low)
				div_low <= wr_byte;
			if (wr_div_high)
				div_high <= wr_byte;
		end
	end

	// Enables only while divisor access is off
	always_ff @(posedge sys_clk_in or negedge rst_sync)
	begin
		if (!rst_sync)
			irq_en <= RST_IRQ_EN;
		else if (wr_irq_en)
			irq_en <= wr_byte[3:0];
	end

	// Line control, FIFO control and aux feature
	always_ff @(posedge sys_clk_in or negedge rst_sync)
	begin
		if (!rst_sync)
		begin
			line_ctrl <= RST_BYTE;
			fifo_en <= 1'b0;
			aux_thresh <= 1'b0;
		end
		else
		begin
			if (wr_line)
				line_ctrl <= wr_byte;
			if (wr_fifo_ctrl)
				fifo_en <= wr_byte[FIFO_EN_BIT];
			if (wr_aux)
				aux_thresh <= wr_byte[AUX_THRESH_BIT];
		end
	end

	// Source qualification
	wire tx_src = aux_thresh ? tx_low_in : tx_empty_in;
	event_vec_t pend;
	assign pend[EV_RX_ERROR] = rx_error_in && irq_en[IE_RX_ERROR];
	assign pend[EV_RX_AVAIL] = rx_avail_in && irq_en[IE_RX_AVAIL];
	assign pend[EV_CHAR_TMO] = char_timeout_in && fifo_en && irq_en[IE_RX_AVAIL];
	assign pend[EV_TX_EMPTY] = tx_src && irq_en[IE_TX_EMPTY];
	assign pend[EV_MODEM] = modem_change_in && irq_en[IE_LINE_CHG];

	wire [3:0] next_id = prio_code(pend);
	wire event_vec_t evt_set = pend & ~pend_q;
	wire event_vec_t evt_clr = wr_status ? wr_byte[EV_W-1:0] : RST_EVENTS;
	wire event_vec_t next_status = (evt_status & ~evt_clr) | evt_set;
	wire next_irq = (next_id != ID_NONE) || ((next_status & evt_mask) != RST_EVENTS);

	// Identity code, event flags and interrupt line
	always_ff @(posedge sys_clk_in or negedge rst_sync)
	begin
		if (!rst_sync)
		begin
			ident_id <= RST_IDENT_ID;
			pend_q <= RST_EVENTS;
			evt_status <= RST_EVENTS;
			evt_mask <= RST_EVENTS;
			irq_out <= 1'b0;
		end
		else
		begin
			ident_id <= next_id;
			pend_q <= pend;
			evt_status <= next_status;
			irq_out <= next_irq;
			if (wr_mask)
				evt_mask <= wr_byte[EV_W-1:0];
		end
	end

	// Read path
	wire ar_hs = s_axi_arvalid_in && s_axi_arready_out;
	wire next_rvalid = ar_hs || (s_axi_rvalid_out && !s_axi_rready_in);
	logic [31:0] rd_word;

	always_comb
	begin
		rd_word = 32'h0000_0000;
		case (s_axi_araddr_in)
			OFS_DIV_LOW:
				rd_word[7:0] = div_sel ? div_low : RST_BYTE;
			OFS_IRQ_EN_DIV_HIGH:
				rd_word[7:0] = div_sel ? div_high : {4'h0, irq_en};
			OFS_IDENT:
			begin
				rd_word[IDENT_FIFO_HI:IDENT_FIFO_LO] = {2{fifo_en}};
				rd_word[IDENT_ID_HI:0] = ident_id;
			end
			OFS_LINE_CTRL:
				rd_word[7:0] = line_ctrl;
			OFS_AUX_CTRL:
				rd_word[AUX_THRESH_BIT] = aux_thresh;
			OFS_EVT_STATUS:
				rd_word[EV_W-1:0] = evt_status;
			OFS_EVT_MASK:
				rd_word[EV_W-1:0] = evt_mask;
			default:
				rd_word = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge sys_clk_in or negedge rst_sync)
	begin
		if (!rst_sync)
		begin
			s_axi_arready_out <= 1'b0;
			s_axi_rvalid_out <= 1'b0;
			s_axi_rdata_out <= 32'h0000_0000;
			s_axi_rresp_out <= RESP_OKAY;
		end
		else
		begin
			s_axi_arready_out <= !next_rvalid;
			s_axi_rvalid_out <= next_rvalid;
			if (ar_hs)
			begin
				s_axi_rdata_out <= rd_word;
				s_axi_rresp_out <= is_mapped(s_axi_araddr_in) ? RESP_OKAY : RESP_SLVERR;
			end
		end
	end

	// Baud generator
	baud_if bif ();
	assign bif.divisor = {div_high, div_low};

	baud_gen u_baud (
		.clk_in(sys_clk_in),
		.rst_b_in(rst_sync),
		.baud(bif.gen)
	);

	assign baud_tick_out = bif.tick;
	assign baud_x16_tick_out = bif.tick_x16;
	assign fifo_enable_out = fifo_en;

	default clocking @(posedge sys_clk_in);
	endclocking
	default disable iff (!rst_sync);

	AST_ID_RX_ERROR:
	assert property (rx_error_in && irq_en[IE_RX_ERROR] |=> ident_id == ID_RX_ERROR)
	else $error("line status not reported first");

	AST_ID_RX_AVAIL:
	assert property (rx_avail_in && irq_en[IE_RX_AVAIL] && !(rx_error_in && irq_en[IE_RX_ERROR])
		|=> ident_id == ID_RX_AVAIL)
	else $error("data available code wrong");

	AST_TMO_NEEDS_FIFO:
	assert property (!fifo_en |=> ident_id != ID_CHAR_TMO)
	else $error("timeout reported with FIFOs off");

	AST_TX_LOW_SEL:
	assert property (aux_thresh && tx_low_in && irq_en[IE_TX_EMPTY] && pend[2:0] == 3'b000
		|=> ident_id == ID_TX_EMPTY)
	else $error("low threshold not used for transmit empty");

	AST_MODEM_GATE:
	assert property (!irq_en[IE_LINE_CHG] |=> ident_id != ID_MODEM)
	else $error("modem code while disabled");

	AST_IRQ_PENDING:
	assert property (ident_id != ID_NONE |-> irq_out)
	else $error("interrupt low while code pending");

	AST_IRQ_QUIET:
	assert property (ident_id == ID_NONE && (evt_status & evt_mask) == RST_EVENTS |-> !irq_out)
	else $error("interrupt high with nothing pending");

	AST_IDENT_READ:
	assert property (ar_hs && s_axi_araddr_in == OFS_IDENT
		|=> s_axi_rvalid_out && s_axi_rdata_out[31:8] == 24'h00_0000 && s_axi_rdata_out[5:4] == 2'b00)
	else $error("identity reserved bits not zero");

	AST_ENABLES_LOCKED:
	assert property (div_sel |=> $stable(irq_en))
	else $error("enables changed under divisor access");

	AST_FIFO_WRITE:
	assert property (wr_fifo_ctrl |=> fifo_enable_out == $past(wr_byte[FIFO_EN_BIT]) [*2])
	else $error("FIFO control write lost");

	AST_SET_WINS:
	assert property (evt_set != RST_EVENTS |=> (evt_status & $past(evt_set)) == $past(evt_set))
	else $error("event flag lost against clear");

	AST_WRITE_RESP:
	assert property (wr_fire |=> s_axi_bvalid_out && s_axi_awready_out && s_axi_wready_out)
	else $error("write response missing");
endmodule

//--- test/uart_irq_ident_test.sv
`timescale 1ns/100ps
module uart_irq_ident_test;
	import uart_ier_pkg::*;
	logic clk;
	logic rst_b;
	logic awvalid, wvalid, bready, arvalid, rready;
	logic [4:0] awaddr, araddr;
	logic [31:0] wdata;
	logic [3:0] wstrb;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic [5:0] src;
	logic irq, fifo_en, btick, xtick;
	logic [31:0] seed;
	int err_total;
	int checks_done;

	uart_irq_ident uut
	(
		.sys_clk_in(clk), .rst_b_in(rst_b),
		.s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready), .s_axi_awaddr_in(awaddr),
		.s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready), .s_axi_wdata_in(wdata), .s_axi_wstrb_in(wstrb),
		.s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready), .s_axi_bresp_out(bresp),
		.s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready), .s_axi_araddr_in(araddr),
		.s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
		.rx_error_in(src[0]), .rx_avail_in(src[1]), .char_timeout_in(src[2]),
		.tx_empty_in(src[3]), .tx_low_in(src[4]), .modem_change_in(src[5]),
		.irq_out(irq), .fifo_enable_out(fifo_en), .baud_tick_out(btick), .baud_x16_tick_out(xtick)
	);

	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	// Highest pending enabled source; bits rx_err, rx_avail, tmo, tx_empty, tx_low, modem
	function automatic logic [3:0] exp_code(logic [3:0] en, logic f, logic a, logic [5:0] s);
		if (s[0] && en[2])
			return 4'h6;
		if (s[1] && en[0])
			return 4'h4;
		if (s[2] && en[0] && f)
			return 4'hc;
		if ((a ? s[4] : s[3]) && en[1])
			return 4'h2;
		if (s[5] && en[3])
			return 4'h0;
		return 4'h1;
	endfunction

	task automatic stop_test();
		$display("Checks %0d, errors %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
		checks_done++;
		if (got !== exp)
		begin
			err_total++;
			$display("ERROR %0t %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] er);
		bit ad;
		bit wd;
		ad = 0;
		wd = 0;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(ad && wd))
		begin
			@(posedge clk);
			if (!ad && awready === 1'b1)
			begin
				ad = 1;
				awvalid <= 1'b0;
			end
			if (!wd && wready === 1'b1)
			begin
				wd = 1;
				wvalid <= 1'b0;
			end
		end
		do @(posedge clk); while (bvalid !== 1'b1);
		check(bresp, er, "write response");
	endtask

	task automatic rd(input logic [4:0] a, output logic [31:0] d, input logic [1:0] er);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge clk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge clk); while (rvalid !== 1'b1);
		d = rdata;
		check(rresp, er, "read response");
	endtask

	task automatic rdchk(input logic [4:0] a, input logic [31:0] exp, input string what);
		logic [31:0] d;
		rd(a, d, RESP_OKAY);
		check(d, exp, what);
	endtask

	task automatic count_ticks(input int n, output int cx, output int cb);
		cx = 0;
		cb = 0;
		repeat (n)
		begin
			@(posedge clk);
			cx += int'(xtick === 1'b1);
			cb += int'(btick === 1'b1);
		end
	endtask

	// Program enables, FIFO and threshold select, drive sources, then read identity
	task automatic run_case(input logic [3:0] en, input logic f, input logic a, input logic [5:0] s);
		logic [3:0] c;
		wr(OFS_IRQ_EN_DIV_HIGH, {28'h0, en}, RESP_OKAY);
		wr(OFS_IDENT, {31'h0, f}, RESP_OKAY);
		wr(OFS_AUX_CTRL, {31'h0, a}, RESP_OKAY);
		src <= s;
		repeat (3) @(posedge clk);
		c = exp_code(en, f, a, s);
		rdchk(OFS_IDENT, {24'h0, f, f, 2'b00, c}, "identity");
		check({31'h0, fifo_en}, {31'h0, f}, "fifo enable");
		check({31'h0, irq}, {31'h0, c != 4'h1}, "irq level");
	endtask

	initial
	begin
		logic [6:0] tbl[8];
		logic [31:0] v;
		logic [31:0] d;
		int cx;
		int cb;
		tbl = '{7'h01, 7'h02, 7'h04, 7'h08, 7'h50, 7'h20, 7'h3e, 7'h48};
		err_total = 0;
		checks_done = 0;
		seed = 32'hbe59_e822;
		rst_b <= 1'b0;
		{awvalid, wvalid, bready, arvalid, rready} <= 5'h00;
		awaddr <= 5'h00;
		araddr <= 5'h00;
		wdata <= 32'h0000_0000;
		wstrb <= 4'hf;
		src <= 6'h00;
		repeat (6) @(posedge clk);
		rst_b <= 1'b1;
		repeat (4) @(posedge clk);
		rdchk(OFS_IDENT, 32'h0000_0001, "identity after reset");
		rdchk(OFS_IRQ_EN_DIV_HIGH, 32'h0000_0000, "enables after reset");
		check({31'h0, irq}, 32'h0000_0000, "irq after reset");
		wr(OFS_LINE_CTRL, 32'h0000_0080, RESP_OKAY);
		rdchk(OFS_IRQ_EN_DIV_HIGH, 32'h0000_0000, "divisor high after reset");
		wr(OFS_IRQ_EN_DIV_HIGH, 32'h0000_00a5, RESP_OKAY);
		rdchk(OFS_IRQ_EN_DIV_HIGH, 32'h0000_00a5, "divisor high");
		wr(OFS_LINE_CTRL, 32'h0000_0000, RESP_OKAY);
		rdchk(OFS_IRQ_EN_DIV_HIGH, 32'h0000_0000, "enables apart");
		wr(OFS_IRQ_EN_DIV_HIGH, 32'h0000_000a, RESP_OKAY);
		rdchk(OFS_IRQ_EN_DIV_HIGH, 32'h0000_000a, "enables");
		wr(OFS_LINE_CTRL, 32'h0000_0080, RESP_OKAY);
		rdchk(OFS_IRQ_EN_DIV_HIGH, 32'h0000_00a5, "divisor high kept");
		// Divisor 4: x16 tick every 4 cycles, baud tick every 64
		wr(OFS_DIV_LOW, 32'h0000_0004, RESP_OKAY);
		wr(OFS_IRQ_EN_DIV_HIGH, 32'h0000_0000, RESP_OKAY);
		repeat (8) @(posedge clk);
		count_ticks(128, cx, cb);
		check(cx, 32, "x16 ticks");
		check(cb, 2, "baud ticks");
		wr(OFS_DIV_LOW, 32'h0000_0000, RESP_OKAY);
		repeat (4) @(posedge clk);
		count_ticks(128, cx, cb);
		check(cx + cb, 0, "ticks with zero divisor");
		wr(OFS_LINE_CTRL, 32'h0000_0000, RESP_OKAY);
		foreach (tbl[i])
			run_case(4'hf, 1'b1, tbl[i][6], tbl[i][5:0]);
		repeat (40)
		begin
			v = rnd();
			run_case(v[3:0], v[4], v[5], v[11:6]);
		end
		rd(5'h1c, d, RESP_SLVERR);
		check(d, 32'h0000_0000, "unmapped read");
		wr(5'h1c, 32'h0000_00ff, RESP_SLVERR);
		// Sticky event: raise, clear by writing one, then masked
		src <= 6'h00;
		wr(OFS_IRQ_EN_DIV_HIGH, 32'h0000_0004, RESP_OKAY);
		wr(OFS_EVT_STATUS, 32'h0000_001f, RESP_OKAY);
		wr(OFS_EVT_MASK, 32'h0000_0001, RESP_OKAY);
		for (int k = 0; k < 2; k++)
		begin
			src <= 6'h01;
			repeat (2) @(posedge clk);
			src <= 6'h00;
			repeat (3) @(posedge clk);
			rdchk(OFS_EVT_STATUS, 32'h0000_0001, "event status");
			check({31'h0, irq}, {31'h0, k == 0}, "event irq");
			wr(OFS_EVT_STATUS, 32'h0000_0001, RESP_OKAY);
			repeat (2) @(posedge clk);
			check({31'h0, irq}, 32'h0000_0000, "irq after clear");
			rdchk(OFS_EVT_STATUS, 32'h0000_0000, "event cleared");
			wr(OFS_EVT_MASK, 32'h0000_0000, RESP_OKAY);
		end
		stop_test();
	end

	initial
	begin
		#80000;
		err_total++;
		$display("ERROR %0t run did not complete", $time);
		stop_test();
	end
endmodule
